// File: pkg/fpllc_params.svh
// register map, reset values, field positions and divider table
// assumes inclusion by bare name from the package and the design files
`ifndef FPLLC_PARAMS_SVH
`define FPLLC_PARAMS_SVH

`define FPLLC_ADDR_W 7
`define FPLLC_DATA_W 9

`define FPLLC_OFS_POWER 7'h01
`define FPLLC_OFS_CLKGEN 7'h06
`define FPLLC_OFS_RATIO_INT 7'h24
`define FPLLC_OFS_FRAC_HI 7'h25
`define FPLLC_OFS_FRAC_MID 7'h26
`define FPLLC_OFS_FRAC_LO 7'h27

`define FPLLC_RST_POWER 9'h000
`define FPLLC_RST_CLKGEN 9'h140
`define FPLLC_RST_RATIO_INT 9'h048
`define FPLLC_RST_FRAC_HI 9'h00c
`define FPLLC_RST_FRAC_MID 9'h093
`define FPLLC_RST_FRAC_LO 9'h0e9

`define FPLLC_MIDRAIL_HI 1
`define FPLLC_MIDRAIL_LO 0
`define FPLLC_MIDRAIL_OFF 2'h0
`define FPLLC_LOOP_EN_BIT 5
`define FPLLC_PWRDN_BIT 7
`define FPLLC_FRACTION_ENABLE_BIT 6
`define FPLLC_PRE_HI 5
`define FPLLC_PRE_LO 4
`define FPLLC_INT_HI 3
`define FPLLC_INT_LO 0
`define FPLLC_FHI_HI 5
`define FPLLC_SRC_BIT 8
`define FPLLC_DIV_HI 7
`define FPLLC_DIV_LO 5

// divider counter width, holds up to twelve times four loop edges
`define FPLLC_CNT_W 6

// fixed post divide after the loop
`define FPLLC_LOOP_POST_DIV 6'h04
// reference pulses arrive on both edges, so two per period
`define FPLLC_REF_EDGES 6'h02
// divide ratio in half units for codes 0..7: 1,1.5,2,3,4,6,8,12
`define FPLLC_DIV_HALF_TABLE {5'h18, 5'h10, 5'h0c, 5'h08, 5'h06, 5'h04, \
	5'h03, 5'h02}

`endif

// File: pkg/fpllc_pkg.sv
// types for the loop clock control block
// assumes fpllc_params.svh is on the include path
`include "fpllc_params.svh"

package fpllc_pkg;

	typedef enum logic [1:0] {
		fpllc_pre_x2,
		fpllc_pre_div1,
		fpllc_pre_div2,
		fpllc_pre_div4
	} fpllc_prescale_t;

	// settings presented to the analog loop
	typedef struct packed {
		logic run;
		logic fraction_enable;
		fpllc_prescale_t prescale;
		logic [3:0] ratio_integer;
		logic [23:0] ratio_fraction;
	} fpllc_loop_cfg_t;

	typedef struct packed {
		logic we;
		logic [`FPLLC_ADDR_W-1:0] addr;
		logic [`FPLLC_DATA_W-1:0] wdata;
	} fpllc_reg_req_t;

endpackage : fpllc_pkg

// File: verilog/fpllc_clock_control.sv
// loop configuration registers and core clock divider
// assumes ref_edge and loop_edge are single-cycle pulses synchronous to clock
// and that software keeps ratio_integer inside its allowed range
`timescale 1ns/1ps
`include "fpllc_params.svh"

module fpllc_clock_control #(
	// divider counter width; must hold the longest period count
	parameter int CNT_W = `FPLLC_CNT_W
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register port
	input wire fpllc_pkg::fpllc_reg_req_t reg_req,
	output logic [`FPLLC_DATA_W-1:0] reg_rdata,
	// clock sources
	input wire logic ref_edge,
	input wire logic loop_edge,
	// loop settings
	output fpllc_pkg::fpllc_loop_cfg_t loop_cfg,
	// core clock and general pin
	input wire logic clock_out_select,
	output logic core_clock,
	output logic gpio_out,
	output logic gpio_oe_n
);
	import fpllc_pkg::*;

	localparam logic [39:0] DIV_HALF = `FPLLC_DIV_HALF_TABLE;

	// a narrower counter would wrap before the divide by twelve ends
	if (CNT_W < `FPLLC_CNT_W) begin : g_cnt_w_check
		$error("divider counter narrower than the longest period");
	end

	logic [`FPLLC_DATA_W-1:0] power_control_one_r;
	logic [`FPLLC_DATA_W-1:0] clock_gen_control_r;
	logic [`FPLLC_DATA_W-1:0] loop_ratio_integer_r;
	logic [`FPLLC_DATA_W-1:0] loop_fraction_high_r;
	logic [`FPLLC_DATA_W-1:0] loop_fraction_mid_r;
	logic [`FPLLC_DATA_W-1:0] loop_fraction_low_r;
	logic [`FPLLC_DATA_W-1:0] rdata_nxt;
	logic loop_run;
	logic [23:0] fraction_full;
	logic src_r;
	logic [2:0] div_code_r;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] term;
	logic [4:0] half_units;
	logic src_edge;
	logic core_tick;
	logic core_clock_r;
	logic gpio_clk_r;
	logic gpio_oe_n_r;
	logic gpio_out_r;
	logic src_idle;
	logic take_cfg;

	// register writes; stored bits of unused fields read back as written, except fraction high bits 8:6, which read zero
	always_ff @(posedge clock) begin
		if (rst) begin
			power_control_one_r <= `FPLLC_RST_POWER;
			clock_gen_control_r <= `FPLLC_RST_CLKGEN;
			loop_ratio_integer_r <= `FPLLC_RST_RATIO_INT;
			loop_fraction_high_r <= `FPLLC_RST_FRAC_HI;
			loop_fraction_mid_r <= `FPLLC_RST_FRAC_MID;
			loop_fraction_low_r <= `FPLLC_RST_FRAC_LO;
		end else if (reg_req.we) begin
			case (reg_req.addr)
			`FPLLC_OFS_POWER: power_control_one_r <= reg_req.wdata;
			`FPLLC_OFS_CLKGEN: clock_gen_control_r <= reg_req.wdata;
			`FPLLC_OFS_RATIO_INT: loop_ratio_integer_r <= reg_req.wdata;
			`FPLLC_OFS_FRAC_HI: loop_fraction_high_r <= reg_req.wdata;
			`FPLLC_OFS_FRAC_MID: loop_fraction_mid_r <= reg_req.wdata;
			`FPLLC_OFS_FRAC_LO: loop_fraction_low_r <= reg_req.wdata;
			default: ;
			endcase
		end
	end

	// readback, unmapped addresses read zero
	// registered, so data follows the address by one cycle
	always_comb begin
		case (reg_req.addr)
		`FPLLC_OFS_POWER: rdata_nxt = power_control_one_r;
		`FPLLC_OFS_CLKGEN: rdata_nxt = clock_gen_control_r;
		`FPLLC_OFS_RATIO_INT: rdata_nxt = loop_ratio_integer_r;
		`FPLLC_OFS_FRAC_HI: rdata_nxt = {3'h0,
			loop_fraction_high_r[`FPLLC_FHI_HI:0]};
		`FPLLC_OFS_FRAC_MID: rdata_nxt = loop_fraction_mid_r;
		`FPLLC_OFS_FRAC_LO: rdata_nxt = loop_fraction_low_r;
		default: rdata_nxt = '0;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= rdata_nxt;
		end
	end

	// loop gating; powerdown bit also stops it
	assign loop_run = power_control_one_r[`FPLLC_LOOP_EN_BIT]
		&& (power_control_one_r[`FPLLC_MIDRAIL_HI:`FPLLC_MIDRAIL_LO]
		!= `FPLLC_MIDRAIL_OFF)
		&& !loop_ratio_integer_r[`FPLLC_PWRDN_BIT];

	assign fraction_full = {loop_fraction_high_r[`FPLLC_FHI_HI:0],
		loop_fraction_mid_r, loop_fraction_low_r};

	// registered so the loop always sees one coherent settings word
	always_ff @(posedge clock) begin
		if (rst) begin
			loop_cfg <= '0;
		end else begin
			loop_cfg.run <= loop_run;
			loop_cfg.fraction_enable <= loop_ratio_integer_r[`FPLLC_FRACTION_ENABLE_BIT];
			loop_cfg.prescale <= fpllc_prescale_t'(
				loop_ratio_integer_r[`FPLLC_PRE_HI:`FPLLC_PRE_LO]);
			loop_cfg.ratio_integer <=
				loop_ratio_integer_r[`FPLLC_INT_HI:`FPLLC_INT_LO];
			// fraction held at zero when fractional divide is off
			loop_cfg.ratio_fraction <=
				loop_ratio_integer_r[`FPLLC_FRACTION_ENABLE_BIT] ?
				fraction_full : 24'h00_0000;
		end
	end

	// a stopped loop has no period in flight, so its settings are replaced
	// at once; waiting for a boundary there would leave the switch to the
	// reference stuck for as long as the loop stays off
	assign src_idle = src_r && !loop_run;
	assign take_cfg = core_tick || src_idle;

	// source and divider are taken at a period boundary, or at once while the loop source is selected and stopped
	// so a setting change never produces a runt pulse
	always_ff @(posedge clock) begin
		if (rst) begin
			src_r <= 1'(`FPLLC_RST_CLKGEN >> `FPLLC_SRC_BIT);
			div_code_r <= 3'(`FPLLC_RST_CLKGEN >> `FPLLC_DIV_LO);
		end else if (take_cfg) begin
			src_r <= clock_gen_control_r[`FPLLC_SRC_BIT];
			div_code_r <=
				clock_gen_control_r[`FPLLC_DIV_HI:`FPLLC_DIV_LO];
		end
	end

	// edges counted per output period: loop 4*div, reference 2 edges*div
	// every term is at least two edges, which keeps core pulses apart
	assign half_units = DIV_HALF[div_code_r*5 +: 5];
	assign term = src_r ?
		CNT_W'(half_units * (`FPLLC_LOOP_POST_DIV >> 1)) :
		CNT_W'(half_units * (`FPLLC_REF_EDGES >> 1));
	assign src_edge = src_r ? (loop_edge && loop_run) : ref_edge;
	assign core_tick = src_edge && (cnt_r == term - CNT_W'(1));

	always_ff @(posedge clock) begin
		if (rst) begin
			cnt_r <= '0;
		end else if (take_cfg) begin
			cnt_r <= '0;
		end else if (src_edge) begin
			cnt_r <= cnt_r + CNT_W'(1);
		end
	end

	// core clock enable, one cycle per divided period
	// an enable pulse rather than a real clock keeps the block on one clock
	always_ff @(posedge clock) begin
		if (rst) begin
			core_clock_r <= 1'b0;
		end else begin
			core_clock_r <= core_tick;
		end
	end

	// general pin carries a square wave at half the core rate
	// a true loop-rate clock cannot leave a one-clock design; half the core
	// rate is the fastest square wave that the enable can carry
	always_ff @(posedge clock) begin
		if (rst) begin
			gpio_clk_r <= 1'b0;
			gpio_oe_n_r <= 1'b1;
			gpio_out_r <= 1'b0;
		end else begin
			gpio_oe_n_r <= !clock_out_select;
			// pin data registered; low whenever the pin is not driven
			gpio_out_r <= clock_out_select
				&& (core_tick ? !gpio_clk_r : gpio_clk_r);
			if (core_tick) begin
				gpio_clk_r <= !gpio_clk_r;
			end
		end
	end

	assign core_clock = core_clock_r;
	assign gpio_out = gpio_out_r;
	assign gpio_oe_n = gpio_oe_n_r;

endmodule : fpllc_clock_control

// File: verif/fpllc_clock_control_properties.sv
// port checker for the loop clock control block
// assumes binding onto fpllc_clock_control
`timescale 1ns/1ps
module fpllc_clock_control_properties (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register port
	input wire fpllc_pkg::fpllc_reg_req_t reg_req,
	input wire logic [8:0] reg_rdata,
	// clock sources
	input wire logic ref_edge,
	input wire logic loop_edge,
	// loop settings
	input wire fpllc_pkg::fpllc_loop_cfg_t loop_cfg,
	// core clock and pin
	input wire logic clock_out_select,
	input wire logic core_clock,
	input wire logic gpio_out,
	input wire logic gpio_oe_n
);
	logic pw, iw, lw;
	logic [8:0] wd1_r, wd2_r;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	assign pw = reg_req.we && reg_req.addr == 7'h01;
	assign iw = reg_req.we && reg_req.addr == 7'h24;
	assign lw = reg_req.we && reg_req.addr == 7'h27;
	// write data two cycles back, when loop_cfg shows it
	always_ff @(posedge clock) begin
		wd1_r <= reg_req.wdata;
		wd2_r <= wd1_r;
	end
	chk_run_gate: assert property (pw && !reg_req.wdata[5] ##1 !pw |->
		##1 !loop_cfg.run) else $error("loop runs while disabled");
	chk_midrail_off: assert property (pw && reg_req.wdata[1:0] == 2'h0
		##1 !pw |-> ##1 !loop_cfg.run) else $error("loop runs at midrail off");
	chk_frac_bit: assert property (iw ##1 !iw |->
		##1 loop_cfg.fraction_enable == wd2_r[6]) else $error("fraction enable wrong");
	chk_prescale_field: assert property (iw ##1 !iw |->
		##1 loop_cfg.prescale == wd2_r[5:4]) else $error("prescale wrong");
	chk_int_field: assert property (iw ##1 !iw |->
		##1 loop_cfg.ratio_integer == wd2_r[3:0]) else $error("integer wrong");
	chk_frac_low: assert property (lw ##1 !lw |-> ##1 (!loop_cfg.fraction_enable ||
		loop_cfg.ratio_fraction[8:0] == wd2_r)) else $error("fraction low wrong");
	chk_frac_zero: assert property (!loop_cfg.fraction_enable |->
		loop_cfg.ratio_fraction == 24'h0) else $error("fraction not cleared");
	chk_core_cause: assert property (core_clock |->
		$past(ref_edge) || $past(loop_edge)) else $error("core pulse uncaused");
	chk_core_gap: assert property (core_clock |=>
		!core_clock) else $error("core pulses adjacent");
	chk_pin_quiet: assert property (gpio_oe_n |->
		!gpio_out) else $error("pin data while undriven");
endmodule : fpllc_clock_control_properties

bind fpllc_clock_control fpllc_clock_control_properties chk_u (.clock(clock),
	.rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.ref_edge(ref_edge), .loop_edge(loop_edge), .loop_cfg(loop_cfg),
	.clock_out_select(clock_out_select), .core_clock(core_clock),
	.gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n));

// File: verif/fpllc_clock_control_tb_top.sv
// bench for the loop clock control block
// assumes package, design and checker compiled first
`timescale 1ns/1ps
module fpllc_clock_control_tb_top;
	import fpllc_pkg::*;
	logic clock = 0, rst = 1, ref_edge = 0, loop_edge = 0;
	logic ref_run = 0, loop_run = 0, clock_out_select = 0;
	logic core_clock, gpio_out, gpio_oe_n;
	logic [8:0] reg_rdata;
	fpllc_reg_req_t reg_req = '0;
	fpllc_loop_cfg_t loop_cfg;
	int miscompares = 0, checks = 0, cycles = 0;
	localparam int half[8] = '{2, 3, 4, 6, 8, 12, 16, 24};
	fpllc_clock_control dut_u (.clock(clock), .rst(rst), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .ref_edge(ref_edge), .loop_edge(loop_edge),
		.loop_cfg(loop_cfg), .clock_out_select(clock_out_select),
		.core_clock(core_clock), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n));
	always #2 clock = ~clock;
	// edges every other cycle, half the densest the divider accepts
	always @(negedge clock) begin
		ref_edge <= ref_run & ~ref_edge;
		loop_edge <= loop_run & ~loop_edge;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles > 20000) begin
			miscompares++;
			print_verdict();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [6:0] a, input logic [8:0] d);
		@(negedge clock);
		reg_req = '{1'b1, a, d};
		@(negedge clock);
		reg_req.we = 1'b0;
		@(negedge clock);
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [8:0] e);
		@(negedge clock);
		reg_req.addr = a;
		@(negedge clock);
		check(reg_rdata, e);
	endtask : rd
	// a divider change lands at a boundary, so skip two periods first
	task automatic period(input int exp);
		int c;
		logic g;
		c = 0;
		repeat (3) begin
			@(negedge clock);
			while (core_clock !== 1'b1) @(negedge clock);
		end
		g = gpio_out;
		do begin
			@(negedge clock);
			c++;
		end while (core_clock !== 1'b1);
		check(c, exp);
		check(gpio_out, clock_out_select ? !g : 1'b0);
	endtask : period
	task automatic t_regs();
		check(loop_cfg, 32'h4831_26e9);
		rd(7'h01, 9'h000);
		rd(7'h06, 9'h140);
		rd(7'h24, 9'h048);
		rd(7'h27, 9'h0e9);
		rd(7'h7f, 9'h000);
		wr(7'h25, 9'h1e1);
		wr(7'h26, 9'h161);
		wr(7'h27, 9'h026);
		rd(7'h25, 9'h021);
		for (int p = 0; p < 4; p++) begin
			wr(7'h24, {3'h0, p[1:0], 4'ha});
			check(loop_cfg, {4'h0 | p[1:0], 4'ha, 24'h0});
		end
		wr(7'h24, 9'h047);
		check(loop_cfg, 32'h4786_c226);
		$display("test regs done");
	endtask : t_regs
	task automatic t_loop();
		clock_out_select = 1'b1;
		loop_run = 1'b1;
		wr(7'h01, 9'h021);
		check(loop_cfg.run, 1'b1);
		period(16);
		check(gpio_oe_n, 1'b0);
		wr(7'h01, 9'h001);
		check(loop_cfg.run, 1'b0);
		wr(7'h01, 9'h021);
		check(loop_cfg.run, 1'b1);
		wr(7'h01, 9'h020);
		check(loop_cfg.run, 1'b0);
		repeat (40) @(negedge clock) check(core_clock, 1'b0);
		$display("test loop done");
	endtask : t_loop
	task automatic t_ref();
		loop_run = 1'b0;
		ref_run = 1'b1;
		for (int k = 0; k < 8; k++) begin
			wr(7'h06, {1'b0, k[2:0], 5'h00});
			period(2 * half[k]);
		end
		clock_out_select = 1'b0;
		period(48);
		$display("test ref done");
	endtask : t_ref
	task automatic print_verdict();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (5) @(negedge clock);
		rst = 1'b0;
		@(negedge clock);
		t_regs();
		t_loop();
		t_ref();
		print_verdict();
	end
endmodule : fpllc_clock_control_tb_top
